// [pkg/pwmec_pkg.sv]
`default_nettype none
package pwmec_pkg;
  // apb address width: byte address is four times the register index
  localparam int          APB_AW     = 18;
  localparam int          IDX_W      = 16;
  // register indices
  localparam logic [15:0] IDX_CTRL0  = 16'hF936;
  localparam logic [15:0] IDX_CTRL1  = 16'hF937;
  localparam logic [15:0] IDX_CTRL2  = 16'hF938;
  localparam logic [15:0] IDX_CTRL3  = 16'hF939;
  // reset values
  localparam logic [7:0]  RST_CTRL0  = 8'h00;
  localparam logic [7:0]  RST_CTRL1  = 8'h00;
  localparam logic [7:0]  RST_CTRL2  = 8'h00;
  localparam logic [7:0]  RST_CTRL3  = 8'h00;
  // writable bit masks, reserved bits read zero
  localparam logic [7:0]  WMASK0     = 8'h3F;
  localparam logic [7:0]  WMASK2     = 8'hB7;
  localparam logic [7:0]  WMASK3     = 8'h3F;
  // control 0 fields
  localparam int          CLK_SEL_LO = 0;
  localparam int          IRQ_PT_LO  = 2;
  localparam int          INV_BIT    = 4;
  localparam int          HALT_BIT   = 5;
  // control 1 fields
  localparam int          RUN_BIT    = 0;
  localparam int          TRIGEN_BIT = 1;
  localparam int          EMERG_BIT  = 5;
  localparam int          FLAG_BIT   = 6;
  localparam int          ACTIVE_BIT = 7;
  // control 2 fields
  localparam int          MODE_LO    = 0;
  localparam int          CLR_BIT    = 2;
  localparam int          EDGE_LO    = 4;
  localparam int          SHOT_BIT   = 7;
  // control 3 fields
  localparam int          SRC_LO     = 0;
  localparam int          BANK_BIT   = 3;
  localparam int          EMSRC_LO   = 4;
  // clock select codes
  localparam logic [1:0]  CLK_LOW    = 2'h0;
  localparam logic [1:0]  CLK_TB     = 2'h1;
  localparam logic [1:0]  CLK_PLL    = 2'h2;
  // external trigger modes
  localparam logic [1:0]  EXT_NONE   = 2'h0;
  localparam logic [1:0]  EXT_START  = 2'h1;
  localparam logic [1:0]  EXT_STOP   = 2'h2;
  localparam logic [1:0]  EXT_BOTH   = 2'h3;
  // edge modes for start and stop
  localparam logic [1:0]  EDG_RR     = 2'h0;
  localparam logic [1:0]  EDG_RSTOP  = 2'h1;
  localparam logic [1:0]  EDG_RSTART = 2'h2;
  localparam logic [1:0]  EDG_FF     = 2'h3;
  // emergency source codes
  localparam logic [1:0]  EM_OFF     = 2'h0;
  localparam logic [1:0]  EM_COMPARATOR_ZERO    = 2'h1;
  localparam logic [1:0]  EM_COMPARATOR_ONE    = 2'h2;
  localparam logic [1:0]  EM_PB0     = 2'h3;
  // trigger source codes; pb0 is code 0 in bank 1, the others are bank 0 codes
  localparam logic [2:0]  TRG_COMPARATOR_ZERO   = 3'h3;
  localparam logic [2:0]  TRG_COMPARATOR_ONE   = 3'h4;
  localparam logic [2:0]  TRG_PB0    = 3'h0;
  localparam logic [2:0]  TRG_PA2    = 3'h2;
  localparam logic [2:0]  TRG_TM9    = 3'h5;
  localparam logic [2:0]  TRG_TMB    = 3'h6;
endpackage : pwmec_pkg
`default_nettype wire

// [design/pwmec_top.sv]
// Summary of operation
// - clock select picks low, timebase or pll
// - interrupt point: period, duty, or both
// - polarity bit sets idle output level
// - forced stop holds output at idle
// - run bit starts and stops counter
// - trigger enable gates external and emergency inputs
// - external stop raises channel interrupt
// - emergency flag set by hardware, write-one clears
// - read-only flag shows internal output level
// - read-only status shows counting in progress
// - external mode: none, start, stop, both
// - clear-on-stop zeroes counter at external stop
// - edge mode chooses start/stop edges
// - single shot stops after one period
// - bank bit plus code picks trigger source
// - emergency source: off, comparator_zero, comparator_one, pb0
// - same trigger and emergency input disables channel
// - channel counter is sixteen-bit up counter
//
// Our own choice: the APB interface to the registers.
`default_nettype none
module pwmec_top #(
  parameter int CNT_W = 16  // counter width
) (
  // clock and reset
  input  wire logic                         CLK,
  input  wire logic                         RESETN,
  // apb slave
  input  wire logic                         PSEL,
  input  wire logic                         PENABLE,
  input  wire logic                         PWRITE,
  input  wire logic [pwmec_pkg::APB_AW-1:0] PADDR,
  input  wire logic [31:0]                  PWDATA,
  input  wire logic [3:0]                   PSTRB,
  output var  logic [31:0]                  PRDATA,
  output logic                              PREADY,
  output logic                              PSLVERR,
  // counting clock enables, one-cycle pulses
  input  wire logic                         LOW_SPEED_CLK_EN,
  input  wire logic                         HIGH_TIMEBASE_CLK_EN,
  input  wire logic                         PLL_CLK_A_EN,
  // trigger and emergency sources
  input  wire logic [2:0]                   PORT_A_IN,
  input  wire logic [7:0]                   PORT_B_IN,
  input  wire logic                         COMPARATOR_ZERO,
  input  wire logic                         COMPARATOR_ONE,
  input  wire logic                         TIMER9_IRQ,
  input  wire logic                         TIMER_B_IRQ,
  input  wire logic                         TIMER_F_IRQ,
  // compare results from period and duty logic
  input  wire logic                         PERIOD_MATCH,
  input  wire logic                         DUTY_MATCH,
  // channel outputs
  output var  logic                         PULSE_CHAN_E_OUT,
  output var  logic [CNT_W-1:0]             COUNT_VALUE,
  output var  logic                         COUNT_TICK,
  output var  logic                         CHAN_IRQ
);

  // the counter width is fixed by the compare logic outside
  if (CNT_W != 16) begin : g_chk
    $error("pwmec_top: CNT_W must be 16");
  end

  // reset synchroniser
  logic rst_meta_r;      // first stage, read only by second
  logic rst_sync_n_r;    // released reset for the design

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_r   <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r   <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  // register state
  logic [7:0]       ctrl0_r, ctrl0_nxt;  // clock, irq point, polarity, halt
  logic             run_r, run_nxt;      // software run bit
  logic             tgen_r, tgen_nxt;    // external trigger enable
  logic             emerg_r, emerg_nxt;  // sticky emergency flag
  logic [7:0]       ctrl2_r, ctrl2_nxt;  // trigger mode, clear, edge, shot
  logic [7:0]       ctrl3_r, ctrl3_nxt;  // trigger and emergency sources
  logic             active_r, active_nxt;// counting in progress
  logic             flag_r, flag_nxt;    // internal output level
  logic [CNT_W-1:0] cnt_r, cnt_nxt;      // channel counter
  logic             irq_r, irq_nxt;      // channel interrupt pulse
  logic             out_r, out_nxt;      // pin level
  logic             tick_r;              // registered count tick
  logic             trg_prev_r;          // last trigger sample
  logic             em_prev_r;           // last emergency sample
  logic [31:0]      rdata_r, rdata_nxt;  // read data

  // field views
  logic [1:0] clk_sel;        // counting clock code
  logic [1:0] irq_pt;         // interrupt point code
  logic       out_invert;     // negative logic
  logic       force_halt;     // forced stop
  logic [1:0] ext_mode;       // external trigger mode
  logic       clear_on_halt;  // clear counter on external stop
  logic [1:0] edge_mode;      // start/stop edge choice
  logic       single_shot_en; // one-shot enable
  logic [2:0] trig_src;       // trigger code
  logic       trig_bank_sel;  // trigger bank
  logic [1:0] emerg_src;      // emergency source code

  assign clk_sel        = ctrl0_r[pwmec_pkg::CLK_SEL_LO +: 2];
  assign irq_pt         = ctrl0_r[pwmec_pkg::IRQ_PT_LO +: 2];
  assign out_invert     = ctrl0_r[pwmec_pkg::INV_BIT];
  assign force_halt     = ctrl0_r[pwmec_pkg::HALT_BIT];
  assign ext_mode       = ctrl2_r[pwmec_pkg::MODE_LO +: 2];
  assign clear_on_halt  = ctrl2_r[pwmec_pkg::CLR_BIT];
  assign edge_mode      = ctrl2_r[pwmec_pkg::EDGE_LO +: 2];
  assign single_shot_en = ctrl2_r[pwmec_pkg::SHOT_BIT];
  assign trig_src       = ctrl3_r[pwmec_pkg::SRC_LO +: 3];
  assign trig_bank_sel  = ctrl3_r[pwmec_pkg::BANK_BIT];
  assign emerg_src      = ctrl3_r[pwmec_pkg::EMSRC_LO +: 2];

  // apb decode, zero wait states
  logic       acc_wr;   // write access phase
  logic       setup_rd; // read setup phase
  logic       hit0, hit1, hit2, hit3;
  logic       mapped;   // address names a register
  logic [7:0] wbyte;    // low byte lane

  assign hit0     = (PADDR[pwmec_pkg::APB_AW-1:2] == pwmec_pkg::IDX_CTRL0) && (PADDR[1:0] == 2'h0);
  assign hit1     = (PADDR[pwmec_pkg::APB_AW-1:2] == pwmec_pkg::IDX_CTRL1) && (PADDR[1:0] == 2'h0);
  assign hit2     = (PADDR[pwmec_pkg::APB_AW-1:2] == pwmec_pkg::IDX_CTRL2) && (PADDR[1:0] == 2'h0);
  assign hit3     = (PADDR[pwmec_pkg::APB_AW-1:2] == pwmec_pkg::IDX_CTRL3) && (PADDR[1:0] == 2'h0);
  assign mapped   = hit0 | hit1 | hit2 | hit3;
  // only byte lane 0 carries register data
  assign acc_wr   = PSEL & PENABLE & PWRITE & mapped & PSTRB[0];
  assign setup_rd = PSEL & ~PENABLE & ~PWRITE;
  assign wbyte    = PWDATA[7:0];
  assign PREADY   = 1'b1;
  // unmapped addresses answer with an error, nothing changes
  assign PSLVERR  = PSEL & PENABLE & ~mapped;

  // counting clock selection; code 11 gives no tick at all
  logic tick;
  always_comb begin
    case (clk_sel)
      pwmec_pkg::CLK_LOW: tick = LOW_SPEED_CLK_EN;
      pwmec_pkg::CLK_TB:  tick = HIGH_TIMEBASE_CLK_EN;
      pwmec_pkg::CLK_PLL: tick = PLL_CLK_A_EN;
      default:            tick = 1'b0;
    endcase
  end

  // trigger source mux
  logic trg_now;
  always_comb begin
    if (trig_bank_sel) begin
      trg_now = PORT_B_IN[trig_src];
    end else if (trig_src <= pwmec_pkg::TRG_PA2) begin
      trg_now = PORT_A_IN[trig_src[1:0]];
    end else begin
      case (trig_src)
        pwmec_pkg::TRG_COMPARATOR_ZERO: trg_now = COMPARATOR_ZERO;
        pwmec_pkg::TRG_COMPARATOR_ONE: trg_now = COMPARATOR_ONE;
        pwmec_pkg::TRG_TM9:  trg_now = TIMER9_IRQ;
        pwmec_pkg::TRG_TMB:  trg_now = TIMER_B_IRQ;
        default:             trg_now = TIMER_F_IRQ;
      endcase
    end
  end

  // emergency source mux, rising edges only
  logic em_now;
  always_comb begin
    case (emerg_src)
      pwmec_pkg::EM_COMPARATOR_ZERO: em_now = COMPARATOR_ZERO;
      pwmec_pkg::EM_COMPARATOR_ONE: em_now = COMPARATOR_ONE;
      pwmec_pkg::EM_PB0:  em_now = PORT_B_IN[0];
      default:            em_now = 1'b0;
    endcase
  end

  // same input for both roles keeps the channel from counting; emergency events still fire
  logic conflict;
  always_comb begin
    conflict = 1'b0;
    case (emerg_src)
      pwmec_pkg::EM_COMPARATOR_ZERO: conflict = ~trig_bank_sel & (trig_src == pwmec_pkg::TRG_COMPARATOR_ZERO);
      pwmec_pkg::EM_COMPARATOR_ONE: conflict = ~trig_bank_sel & (trig_src == pwmec_pkg::TRG_COMPARATOR_ONE);
      pwmec_pkg::EM_PB0:  conflict = trig_bank_sel & (trig_src == pwmec_pkg::TRG_PB0);
      default:            conflict = 1'b0;
    endcase
  end

  // edge detection; timer sources assume rising/rising mode
  logic trg_rise, trg_fall, em_rise;
  assign trg_rise = trg_now & ~trg_prev_r;
  assign trg_fall = ~trg_now & trg_prev_r;
  assign em_rise  = em_now & ~em_prev_r;

  // external start and stop decode, only with trigger enabled
  logic ext_start, ext_stop, em_evt;
  always_comb begin
    ext_start = 1'b0;
    ext_stop  = 1'b0;
    case (ext_mode)
      pwmec_pkg::EXT_START: ext_start = trg_rise;
      pwmec_pkg::EXT_STOP:  ext_stop  = trg_rise;
      pwmec_pkg::EXT_BOTH: begin
        case (edge_mode)
          pwmec_pkg::EDG_RR: begin
            ext_start = trg_rise & ~active_r;
            ext_stop  = trg_rise & active_r;
          end
          pwmec_pkg::EDG_RSTOP: begin
            ext_start = trg_fall;
            ext_stop  = trg_rise;
          end
          pwmec_pkg::EDG_RSTART: begin
            ext_start = trg_rise;
            ext_stop  = trg_fall;
          end
          default: begin
            ext_start = trg_fall & ~active_r;
            ext_stop  = trg_fall & active_r;
          end
        endcase
      end
      default: ;
    endcase
    ext_start = ext_start & tgen_r & ~active_r;
    ext_stop  = ext_stop & tgen_r & active_r;
  end
  assign em_evt = tgen_r & em_rise & (emerg_src != pwmec_pkg::EM_OFF);

  // match events only count while the channel runs on a tick
  logic period_hit, duty_hit;
  assign period_hit = tick & active_r & PERIOD_MATCH;
  assign duty_hit   = tick & active_r & DUTY_MATCH;

  // next-state logic for registers, counter and output
  always_comb begin
    ctrl0_nxt  = ctrl0_r;
    run_nxt    = run_r;
    tgen_nxt   = tgen_r;
    emerg_nxt  = emerg_r;
    ctrl2_nxt  = ctrl2_r;
    ctrl3_nxt  = ctrl3_r;
    cnt_nxt    = cnt_r;
    flag_nxt   = flag_r;
    rdata_nxt  = rdata_r;
    // software writes; edits while running are not blocked
    if (acc_wr && hit0) begin
      ctrl0_nxt = wbyte & pwmec_pkg::WMASK0;
    end
    if (acc_wr && hit1) begin
      run_nxt  = wbyte[pwmec_pkg::RUN_BIT];
      tgen_nxt = wbyte[pwmec_pkg::TRIGEN_BIT];
      if (wbyte[pwmec_pkg::EMERG_BIT]) begin
        emerg_nxt = 1'b0;
      end
    end
    if (acc_wr && hit2) begin
      ctrl2_nxt = wbyte & pwmec_pkg::WMASK2;
    end
    if (acc_wr && hit3) begin
      ctrl3_nxt = wbyte & pwmec_pkg::WMASK3;
    end
    // hardware events outrank a write in the same cycle
    if (ext_start) begin
      run_nxt = 1'b1;
    end
    if (period_hit && single_shot_en) begin
      run_nxt = 1'b0;
    end
    if (ext_stop) begin
      run_nxt = 1'b0;
    end
    if (em_evt) begin
      run_nxt   = 1'b0;
      emerg_nxt = 1'b1;
    end
    // counter: up count, wraps at period match
    if (tick && active_r) begin
      if (period_hit) begin
        cnt_nxt = '0;
      end else begin
        cnt_nxt = CNT_W'(cnt_r + 1'b1);
      end
    end
    if (ext_stop && clear_on_halt) begin
      cnt_nxt = '0;
    end
    // output flag: high at period start, low at duty match
    if (duty_hit) begin
      flag_nxt = 1'b0;
    end
    if (period_hit) begin
      flag_nxt = 1'b1;
    end
    // read data captured in setup, shown in access
    if (setup_rd) begin
      rdata_nxt = 32'h0000_0000;
      if (hit0) begin
        rdata_nxt[7:0] = ctrl0_r;
      end
      if (hit1) begin
        rdata_nxt[pwmec_pkg::RUN_BIT]    = run_r;
        rdata_nxt[pwmec_pkg::TRIGEN_BIT] = tgen_r;
        rdata_nxt[pwmec_pkg::EMERG_BIT]  = emerg_r;
        rdata_nxt[pwmec_pkg::FLAG_BIT]   = flag_r;
        rdata_nxt[pwmec_pkg::ACTIVE_BIT] = active_r;
      end
      if (hit2) begin
        rdata_nxt[7:0] = ctrl2_r;
      end
      if (hit3) begin
        rdata_nxt[7:0] = ctrl3_r;
      end
    end
  end

  // status, pin level and interrupt
  always_comb begin
    active_nxt = run_nxt & ~conflict;
    // halted pin sits at the polarity level, otherwise at flag xor polarity
    if (force_halt) begin
      out_nxt = out_invert;
    end else begin
      out_nxt = flag_nxt ^ out_invert;
    end
    irq_nxt = (period_hit & (irq_pt[1] | ~irq_pt[0]))
            | (duty_hit & (irq_pt[1] | irq_pt[0]))
            | ext_stop
            | em_evt;
  end

  // state registers
  always_ff @(posedge CLK or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      ctrl0_r    <= pwmec_pkg::RST_CTRL0;
      run_r      <= pwmec_pkg::RST_CTRL1[pwmec_pkg::RUN_BIT];
      tgen_r     <= pwmec_pkg::RST_CTRL1[pwmec_pkg::TRIGEN_BIT];
      emerg_r    <= pwmec_pkg::RST_CTRL1[pwmec_pkg::EMERG_BIT];
      ctrl2_r    <= pwmec_pkg::RST_CTRL2;
      ctrl3_r    <= pwmec_pkg::RST_CTRL3;
      active_r   <= pwmec_pkg::RST_CTRL1[pwmec_pkg::ACTIVE_BIT];
      flag_r     <= pwmec_pkg::RST_CTRL1[pwmec_pkg::FLAG_BIT];
      cnt_r      <= '0;
      irq_r      <= 1'b0;
      out_r      <= 1'b0;
      tick_r     <= 1'b0;
      trg_prev_r <= 1'b0;
      em_prev_r  <= 1'b0;
      rdata_r    <= 32'h0000_0000;
    end else begin
      ctrl0_r    <= ctrl0_nxt;
      run_r      <= run_nxt;
      tgen_r     <= tgen_nxt;
      emerg_r    <= emerg_nxt;
      ctrl2_r    <= ctrl2_nxt;
      ctrl3_r    <= ctrl3_nxt;
      active_r   <= active_nxt;
      flag_r     <= flag_nxt;
      cnt_r      <= cnt_nxt;
      irq_r      <= irq_nxt;
      out_r      <= out_nxt;
      tick_r     <= tick & active_r;
      trg_prev_r <= trg_now;
      em_prev_r  <= em_now;
      rdata_r    <= rdata_nxt;
    end
  end

  // outputs from flip-flops
  assign PRDATA           = rdata_r;
  assign PULSE_CHAN_E_OUT = out_r;
  assign COUNT_VALUE      = cnt_r;
  assign COUNT_TICK       = tick_r;
  assign CHAN_IRQ         = irq_r;

endmodule // pwmec_top
`default_nettype wire

// [verification/pwmec_assertions.sv]
`default_nettype none
module pwmec_assertions #(
  parameter int CNT_W = 16  // counter width, as in the design
) (
  // clock and reset
  input wire logic                         CLK,
  input wire logic                         RESETN,
  // apb slave side
  input wire logic                         PSEL,
  input wire logic                         PENABLE,
  input wire logic                         PWRITE,
  input wire logic [pwmec_pkg::APB_AW-1:0] PADDR,
  input wire logic [31:0]                  PWDATA,
  input wire logic [3:0]                   PSTRB,
  input wire logic [31:0]                  PRDATA,
  input wire logic                         PREADY,
  input wire logic                         PSLVERR,
  // counting inputs and channel outputs
  input wire logic                         LOW_SPEED_CLK_EN,
  input wire logic                         HIGH_TIMEBASE_CLK_EN,
  input wire logic                         PLL_CLK_A_EN,
  input wire logic                         PERIOD_MATCH,
  input wire logic                         PULSE_CHAN_E_OUT,
  input wire logic [CNT_W-1:0]             COUNT_VALUE,
  input wire logic                         COUNT_TICK
);
  logic acc;     // access phase
  logic en_any;  // some counting tick offered
  logic mapped;  // aligned hit on one of the four registers
  logic wr0;     // byte write to control 0
  logic wr1;     // byte write to control 1
  assign acc    = PSEL & PENABLE;
  assign en_any = LOW_SPEED_CLK_EN | HIGH_TIMEBASE_CLK_EN | PLL_CLK_A_EN;
  assign mapped = PADDR[1:0] == 2'b00 && PADDR[17:2] >= pwmec_pkg::IDX_CTRL0 && PADDR[17:2] <= pwmec_pkg::IDX_CTRL3;
  assign wr0    = acc & PWRITE & PSTRB[0] & (PADDR == {pwmec_pkg::IDX_CTRL0, 2'b00});
  assign wr1    = acc & PWRITE & PSTRB[0] & (PADDR == {pwmec_pkg::IDX_CTRL1, 2'b00});

  // one clock domain, reset pin as the only disable
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);

  ready_const_a: assert property (acc |-> PREADY)
    else $error("pready low in an access phase");
  bad_addr_a: assert property (acc && !mapped |-> PSLVERR)
    else $error("unmapped access not refused");
  good_addr_a: assert property (acc && mapped |-> !PSLVERR)
    else $error("mapped access refused");
  rdata_clean_a: assert property (acc && !PWRITE |-> PRDATA[31:8] == 24'h00_0000 && (mapped || PRDATA[7:0] == 8'h00))
    else $error("read data carries stray bits");
  tick_cause_a: assert property (COUNT_TICK |-> $past(en_any))
    else $error("count tick without an offered tick");
  count_step_a: assert property (COUNT_TICK && !$past(PERIOD_MATCH) |->
      COUNT_VALUE == CNT_W'($past(COUNT_VALUE) + 1'b1))
    else $error("counter did not step by one");
  period_wrap_a: assert property (COUNT_TICK && $past(PERIOD_MATCH) |-> COUNT_VALUE == '0)
    else $error("counter not cleared on period hit");
  clear_zero_a: assert property ($changed(COUNT_VALUE) && !$past(en_any) |-> COUNT_VALUE == '0)
    else $error("counter moved without a tick");
  stop_write_a: assert property (wr1 && PWDATA[1:0] == 2'b00 |=> ##2 (!COUNT_TICK && $stable(COUNT_VALUE)) [*4])
    else $error("counter kept running after stop");
  halt_level_a: assert property (wr0 && PWDATA[5] |=> ##2 PULSE_CHAN_E_OUT == $past(PWDATA[4], 3))
    else $error("forced stop level wrong");
endmodule // pwmec_assertions

bind pwmec_top pwmec_assertions #(.CNT_W(CNT_W)) u_pwmec_assertions (
  .CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .LOW_SPEED_CLK_EN(LOW_SPEED_CLK_EN), .HIGH_TIMEBASE_CLK_EN(HIGH_TIMEBASE_CLK_EN),
  .PLL_CLK_A_EN(PLL_CLK_A_EN), .PERIOD_MATCH(PERIOD_MATCH), .PULSE_CHAN_E_OUT(PULSE_CHAN_E_OUT),
  .COUNT_VALUE(COUNT_VALUE), .COUNT_TICK(COUNT_TICK)
);
`default_nettype wire

// [verification/pwm_channel_e_control_bench.sv]
`default_nettype none
module pwm_channel_e_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // apb and misc design pins
  logic        CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [17:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rdat;
  logic [3:0]  PSTRB;
  logic [2:0]  en;   // tick enables: low, timebase, pll
  logic [15:0] src;  // sources indexed by {bank, code}
  logic        PERIOD_MATCH, DUTY_MATCH, PULSE_CHAN_E_OUT, COUNT_TICK, CHAN_IRQ, err, irq;
  logic [15:0] COUNT_VALUE;
  int          n_fail, checks;

  pwmec_top u_pwmec_top (
    .CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .LOW_SPEED_CLK_EN(en[0]), .HIGH_TIMEBASE_CLK_EN(en[1]), .PLL_CLK_A_EN(en[2]),
    .PORT_A_IN(src[2:0]), .PORT_B_IN(src[15:8]), .COMPARATOR_ZERO(src[3]), .COMPARATOR_ONE(src[4]),
    .TIMER9_IRQ(src[5]), .TIMER_B_IRQ(src[6]), .TIMER_F_IRQ(src[7]), .PERIOD_MATCH(PERIOD_MATCH),
    .DUTY_MATCH(DUTY_MATCH), .PULSE_CHAN_E_OUT(PULSE_CHAN_E_OUT), .COUNT_VALUE(COUNT_VALUE),
    .COUNT_TICK(COUNT_TICK), .CHAN_IRQ(CHAN_IRQ)
  );

  // 100 MHz clock
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic print_verdict;
    if (n_fail == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // four-state compare, counted
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // byte address is four times the register index
  function automatic logic [17:0] adr(input int i);
    return {pwmec_pkg::IDX_CTRL0 + 16'(i), 2'b00};
  endfunction

  function automatic logic [7:0] wmask(input int i);
    return (i == 0) ? pwmec_pkg::WMASK0 : (i == 2) ? pwmec_pkg::WMASK2 : pwmec_pkg::WMASK3;
  endfunction

  // {start, stop} asked for by one edge; r is a rising edge
  function automatic logic [1:0] act(input logic [1:0] m, input logic [1:0] e, input logic r);
    case (m)
      2'd1: return {r, 1'b0};
      2'd2: return {1'b0, r};
      2'd3: return (e == 2'd0) ? {r, r} : (e == 2'd1) ? {!r, r} : (e == 2'd2) ? {r, !r} : {!r, !r};
      default: return 2'b00;
    endcase
  endfunction

  // one transfer, held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [17:0] a, input logic [7:0] d);
    int n;
    n = 0;
    // one idle edge, so psel is never set again in the step that dropped it
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= {24'h00_0000, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    rdat = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (PREADY !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
  endtask

  task automatic wr(input int i, input logic [7:0] d);
    apb(1'b1, adr(i), d);
  endtask

  // read and compare the bits under mask m
  task automatic rd(input int i, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, adr(i), 8'h00);
    cmp(rdat & {24'h00_0000, m}, {24'h00_0000, e});
  endtask

  // gather interrupt pulses over n cycles
  task automatic watch(input int n);
    irq = 1'b0;
    repeat (n) begin
      @(posedge CLK);
      irq = irq | CHAN_IRQ;
    end
  endtask

  // one tick on enable k, with optional compare hits
  task automatic tick(input int k, input logic pm, input logic dm);
    repeat (2) @(posedge CLK);
    en <= 3'b001 << k;
    PERIOD_MATCH <= pm;
    DUTY_MATCH <= dm;
    @(posedge CLK);
    en <= 3'b000;
    PERIOD_MATCH <= 1'b0;
    DUTY_MATCH <= 1'b0;
    watch(3);
  endtask

  task automatic drive(input int k, input logic v);
    src[k] <= v;
    watch(5);
  endtask

  // stop, wait until counting ends, then rewrite the set-up
  task automatic cfg(input logic [7:0] c0, input logic [7:0] c2, input logic [7:0] c3);
    int n;
    n = 0;
    wr(1, 8'h00);
    do begin
      apb(1'b0, adr(1), 8'h00);
      n++;
    end while (rdat[7] !== 1'b0 && n < 20);
    if (rdat[7] !== 1'b0) begin
      n_fail++;
      print_verdict();
    end
    wr(0, c0);
    wr(2, c2);
    wr(3, c3);
  endtask

  initial begin
    int k;
    logic [15:0] cv;
    logic [7:0]  d;
    logic [1:0]  a, m, e;
    logic        on, cl, inv, st;
    {RESETN, PSEL, PENABLE, PWRITE, PADDR, PWDATA, en, src} = '0;
    {PERIOD_MATCH, DUTY_MATCH, n_fail, checks} = '0;
    PSTRB = 4'hF;
    repeat (3) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (4) @(posedge CLK);
    k = $urandom(35642);
    // reset values, then an unmapped place
    for (int i = 0; i < 4; i++) rd(i, 8'hFF, 8'h00);
    apb(1'b0, adr(4), 8'h00);
    cmp(rdat, 32'h0000_0000);
    cmp(32'(err), 32'h0000_0001);
    // read back under the writable masks; a write without lane 0 is dropped
    for (int i = 0; i < 4; i++) begin
      if (i == 1) continue;
      d = 8'($urandom);
      wr(i, d);
      PSTRB <= 4'hE;
      wr(i, ~d);
      PSTRB <= 4'hF;
      rd(i, 8'hFF, d & wmask(i));
    end
    // each clock code counts only its own tick, code 3 none
    for (int c = 0; c < 4; c++) begin
      cfg(8'(c), 8'h00, 8'h00);
      wr(1, 8'h01);
      rd(1, 8'h83, 8'h81);
      for (int j = 0; j < 3; j++) begin
        cv = COUNT_VALUE;
        tick(j, 1'b0, 1'b0);
        cmp(COUNT_VALUE, cv + 16'(j == c));
      end
    end
    // interrupt point, output flag and polarity
    for (int p = 0; p < 4; p++) begin
      inv = 1'($urandom);
      cfg({3'b000, inv, 2'(p), 2'b00}, 8'h00, 8'h00);
      repeat (2) @(posedge CLK);
      cmp(PULSE_CHAN_E_OUT, inv);
      wr(1, 8'h01);
      tick(0, 1'b1, 1'b0);
      cmp({irq, COUNT_VALUE, PULSE_CHAN_E_OUT}, {p != 1, 16'h0000, !inv});
      rd(1, 8'hC1, 8'hC1);
      tick(0, 1'b0, 1'b1);
      cmp({irq, PULSE_CHAN_E_OUT}, {p != 0, inv});
      rd(1, 8'h40, 8'h00);
    end
    // forced stop holds the inverted idle level while the flag is set
    cfg(8'h30, 8'h00, 8'h00);
    wr(1, 8'h01);
    tick(0, 1'b1, 1'b0);
    cmp(PULSE_CHAN_E_OUT, 1'b1);
    // single shot ends counting at the period hit
    cfg(8'h00, 8'h80, 8'h00);
    wr(1, 8'h01);
    tick(0, 1'b1, 1'b0);
    rd(1, 8'h81, 8'h00);
    // external modes and edge modes on port a pin 0; last pass with triggers off
    for (int j = 0; j < 8; j++) begin
      m = (j < 3) ? 2'(j) : 2'd3;
      e = (j > 3 && j < 7) ? 2'(j - 3) : 2'd0;
      cl = 1'($urandom);
      on = (m == 2'd2);
      cfg(8'h00, {2'b00, e, 1'b0, cl, m}, 8'h00);
      wr(1, {6'h00, j != 7, on});
      for (int s = 0; s < 4; s++) begin
        cv = COUNT_VALUE;
        a = (j == 7) ? 2'b00 : act(m, e, s[0] == 1'b0);
        drive(0, s[0] == 1'b0);
        st = on && a[0];
        on = st ? 1'b0 : (on | a[1]);
        cmp(irq, st);
        if (st) cmp(COUNT_VALUE, cl ? 16'h0000 : cv);
        rd(1, 8'h80, {on, 7'h00});
        if (on) tick(0, 1'b0, 1'b0);
      end
    end
    // emergency sources: stop, flag, interrupt, write-one clear
    for (int s = 1; s < 4; s++) begin
      cfg(8'h00, 8'h00, {2'b00, 2'(s), 4'h1});
      wr(1, 8'h03);
      drive((s == 1) ? 3 : (s == 2) ? 4 : 8, 1'b1);
      cmp(irq, 1'b1);
      rd(1, 8'hA3, 8'h22);
      wr(1, 8'h02);
      rd(1, 8'h20, 8'h20);
      wr(1, 8'h22);
      rd(1, 8'h20, 8'h00);
      src <= 16'h0000;
    end
    // same comparator as trigger and emergency source: channel stays idle
    cfg(8'h00, 8'h00, 8'h13);
    wr(1, 8'h01);
    rd(1, 8'h81, 8'h01);
    // random bank and code: line k^1 leaves the channel idle, the selected line starts counting
    for (int t = 0; t < 6; t++) begin
      k = $urandom % 16;
      cfg(8'h00, 8'h01, 8'(k));
      wr(1, 8'h02);
      drive(k ^ 1, 1'b1);
      rd(1, 8'h80, 8'h00);
      drive(k, 1'b1);
      rd(1, 8'h80, 8'h80);
      src <= 16'h0000;
    end
    print_verdict();
  end
endmodule // pwm_channel_e_control_bench
`default_nettype wire
